//--- design/cbss_consts.svh
`ifndef CBSS_CONSTS_SVH
`define CBSS_CONSTS_SVH

`define CBSS_CAPPTR_OFS    8'h14
`define CBSS_SECSTAT_OFS   8'h16
`define CBSS_PM_CAP_OFS    8'ha0
`define CBSS_PM_CSR_OFS    8'ha4
`define CBSS_CAPPTR_VAL    8'ha0
`define CBSS_STAT_RESET    16'h0200
`define CBSS_STAT_HARD     16'h0200
`define CBSS_STAT_W1C      16'hf900
`define CBSS_BIT_DET_PERR  4'hf
`define CBSS_BIT_SERR      4'he
`define CBSS_BIT_MABORT    4'hd
`define CBSS_BIT_TA_RX     4'hc
`define CBSS_BIT_TA_TX     4'hb
`define CBSS_BIT_DPAR      4'h8
`define CBSS_SEL_TIMING    2'h1
`define CBSS_PM_CAP_ID     8'h01
`define CBSS_PM_NEXT       8'h00
`define CBSS_PM_PMC        16'h0002

`endif

//--- design/cbss_pkg.sv
package cbss_pkg;
	typedef logic [15:0] cbss_status_t;
	typedef logic [31:0] cbss_word_t;
	typedef enum logic [1:0] {
		CBSS_D0,
		CBSS_D1,
		CBSS_D2,
		CBSS_D3
	} cbss_pstate_t;
endpackage

//--- design/cbss_socket_status.sv
`include "cbss_consts.svh"

module cbss_socket_status
	import cbss_pkg::*;
(
	input  wire logic         clk,         // Host bus clock
	input  wire logic         reset,       // Sync reset, high
	input  wire logic         serr_n,      // Card system error pin
	input  wire logic         perr_n,      // Card parity error pin
	input  wire logic         is_master,   // Bridge owns the data phase
	input  wire logic         perr_resp,   // Parity response enable
	input  wire logic         addr_perr,   // Address parity error pulse
	input  wire logic         data_perr,   // Data parity error pulse
	input  wire logic         mabort,      // Master abort pulse
	input  wire logic         ta_rx,       // Target abort received pulse
	input  wire logic         ta_tx,       // Target abort signaled pulse
	input  wire cbss_status_t clear_bits,  // Write-one-to-clear bits
	output cbss_status_t      status       // Status word
);
	logic [2:0]   serr_s;
	logic [2:0]   perr_s;
	logic         serr_lvl;
	logic         perr_lvl;
	cbss_status_t evt;
	cbss_status_t set_bits;
	cbss_status_t next_evt;
	logic         parity_error_seen;
	logic         card_system_error_seen;
	logic         master_data_parity_flag;

	// Pins cross from the card clock; filtered level updates on agreement
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			serr_s   <= 3'h7;
			perr_s   <= 3'h7;
			serr_lvl <= 1'b1;
			perr_lvl <= 1'b1;
		end
		else
		begin
			serr_s <= {serr_s[1:0], serr_n};
			perr_s <= {perr_s[1:0], perr_n};
			if (serr_s[1] == serr_s[2])
				serr_lvl <= serr_s[2];
			if (perr_s[1] == perr_s[2])
				perr_lvl <= perr_s[2];
		end
	end

	assign parity_error_seen       = addr_perr | data_perr;
	assign card_system_error_seen  = ~serr_lvl;
	assign master_data_parity_flag = ~perr_lvl & is_master & perr_resp;

	always_comb
	begin
		set_bits                    = 16'h0000;
		set_bits[`CBSS_BIT_DET_PERR] = parity_error_seen;
		set_bits[`CBSS_BIT_SERR]     = card_system_error_seen;
		set_bits[`CBSS_BIT_MABORT]   = mabort;
		set_bits[`CBSS_BIT_TA_RX]    = ta_rx;
		set_bits[`CBSS_BIT_TA_TX]    = ta_tx;
		set_bits[`CBSS_BIT_DPAR]     = master_data_parity_flag;
	end

	// Set is ORed in after the clear so a coinciding event survives
	assign next_evt = ((evt & ~clear_bits) | set_bits) & `CBSS_STAT_W1C;

	always_ff @(posedge clk)
	begin
		if (reset)
			evt <= 16'h0000;
		else
			evt <= next_evt;
	end

	// Hardwired timing code; fixed flags and reserved bits stay zero
	assign status = evt | `CBSS_STAT_HARD;
endmodule // cbss_socket_status

//--- design/cbss_cfg_regs.sv
`include "cbss_consts.svh"

module cbss_cfg_regs
	import cbss_pkg::*;
(
	input  wire logic        clk,             // Host bus clock, 125 MHz
	input  wire logic        reset,           // Sync reset, high
	input  wire logic        cfg_req,         // Config access strobe
	input  wire logic        cfg_write,       // 1 write, 0 read
	input  wire logic        cfg_func,        // Socket function number
	input  wire logic [7:0]  cfg_addr,        // Config byte address
	input  wire logic [3:0]  cfg_be,          // Byte enables
	input  wire cbss_word_t  cfg_wdata,       // Write data
	output logic             cfg_ack,         // Access done pulse
	output cbss_word_t       cfg_rdata,       // Read data
	input  wire logic [1:0]  card_serr_n,     // Card system error pins
	input  wire logic [1:0]  card_perr_n,     // Card parity error pins
	input  wire logic [1:0]  bus_master,      // Bridge is card-bus master
	input  wire logic [1:0]  parity_resp_en,  // Bridge control bit 0
	input  wire logic [1:0]  addr_perr,       // Address parity error
	input  wire logic [1:0]  data_perr,       // Data parity error
	input  wire logic [1:0]  master_abort,    // Master abort seen
	input  wire logic [1:0]  target_abort_rx, // Target abort received
	input  wire logic [1:0]  target_abort_tx  // Target abort signaled
);
	logic [7:0]   ofs_cap;
	logic [7:0]   ofs_stat;
	logic [7:0]   ofs_pmcap;
	logic [7:0]   ofs_pmcsr;
	logic         hit_capstat;
	logic         hit_pmcap;
	logic         hit_pmcsr;
	logic         wr_capstat;
	logic         wr_pmcsr;
	cbss_status_t clr_word;
	cbss_status_t sock_stat [2];
	cbss_pstate_t pstate [2];
	cbss_word_t   next_rdata;
	cbss_word_t   sel_capstat;
	cbss_word_t   sel_pmcap;
	cbss_word_t   sel_pmcsr;

	assign ofs_cap   = `CBSS_CAPPTR_OFS;
	assign ofs_stat  = `CBSS_SECSTAT_OFS;
	assign ofs_pmcap = `CBSS_PM_CAP_OFS;
	assign ofs_pmcsr = `CBSS_PM_CSR_OFS;

	// Dword decode; pointer and status share the dword at 14h
	assign hit_capstat = (cfg_addr[7:2] == ofs_cap[7:2]) || (cfg_addr[7:2] == ofs_stat[7:2]);
	assign hit_pmcap   = cfg_addr[7:2] == ofs_pmcap[7:2];
	assign hit_pmcsr   = cfg_addr[7:2] == ofs_pmcsr[7:2];
	assign wr_capstat  = cfg_req & cfg_write & hit_capstat;
	assign wr_pmcsr    = cfg_req & cfg_write & hit_pmcsr & cfg_be[0];

	// Status lives in the upper half; pointer byte has no write path
	assign clr_word = {cfg_be[3] ? cfg_wdata[31:24] : 8'h00,
		cfg_be[2] ? cfg_wdata[23:16] : 8'h00};

	genvar s;
	generate
		for (s = 0; s < 2; s++)
		begin : g_sock
			logic         sel;
			cbss_status_t clr;

			assign sel = cfg_func == 1'(s);
			// Each socket sees only its own writes
			assign clr = (wr_capstat & sel) ? clr_word : 16'h0000;

			cbss_socket_status u_stat (
				.clk        (clk),
				.reset      (reset),
				.serr_n     (card_serr_n[s]),
				.perr_n     (card_perr_n[s]),
				.is_master  (bus_master[s]),
				.perr_resp  (parity_resp_en[s]),
				.addr_perr  (addr_perr[s]),
				.data_perr  (data_perr[s]),
				.mabort     (master_abort[s]),
				.ta_rx      (target_abort_rx[s]),
				.ta_tx      (target_abort_tx[s]),
				.clear_bits (clr),
				.status     (sock_stat[s])
			);

			// Only the power state field is kept; other bits read zero
			always_ff @(posedge clk)
			begin
				if (reset)
					pstate[s] <= CBSS_D0;
				else if (wr_pmcsr & sel)
					pstate[s] <= cbss_pstate_t'(cfg_wdata[1:0]);
			end
		end
	endgenerate

	// Pointer constant per function; no storage behind it
	assign sel_capstat = {sock_stat[cfg_func], 8'h00, `CBSS_CAPPTR_VAL};
	assign sel_pmcap   = {`CBSS_PM_PMC, `CBSS_PM_NEXT, `CBSS_PM_CAP_ID};
	assign sel_pmcsr   = {30'h0, pstate[cfg_func]};

	always_comb
	begin
		if (hit_capstat)
			next_rdata = sel_capstat;
		else if (hit_pmcap)
			next_rdata = sel_pmcap;
		else if (hit_pmcsr)
			next_rdata = sel_pmcsr;
		else
			next_rdata = 32'h00000000;
	end

	// Answer one cycle after the strobe; data holds until next read
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cfg_ack   <= 1'b0;
			cfg_rdata <= 32'h00000000;
		end
		else
		begin
			cfg_ack <= cfg_req;
			if (cfg_req & ~cfg_write)
				cfg_rdata <= next_rdata;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence rd_capstat_s;
		cfg_req && !cfg_write && hit_capstat;
	endsequence

	sequence rd_pmcap_s;
		cfg_req && !cfg_write && hit_pmcap;
	endsequence

	sequence clr_perr0_s;
		wr_capstat && !cfg_func && cfg_be[3] && cfg_wdata[31];
	endsequence

	sequence quiet_perr0_s;
		!addr_perr[0] && !data_perr[0];
	endsequence

	sequence serr0_held_s;
		!card_serr_n[0] [*6];
	endsequence

	sequence clr_perr1_s;
		wr_capstat && cfg_func && cfg_be[3] && cfg_wdata[31];
	endsequence

	sequence quiet_perr1_s;
		!addr_perr[1] && !data_perr[1];
	endsequence

	sequence serr1_held_s;
		!card_serr_n[1] [*6];
	endsequence

	access_ack_a: assert property (
		cfg_req |=> cfg_ack ##1 (!cfg_ack || $past(cfg_req)))
		else $error("ack not one cycle after request");

	capptr_read_a: assert property (
		rd_capstat_s |=> cfg_ack && cfg_rdata[7:0] == 8'ha0)
		else $error("pointer did not read a0");

	capptr_wr_a: assert property (
		wr_capstat ##[1:6] rd_capstat_s |=> cfg_rdata[7:0] == 8'ha0)
		else $error("pointer changed by write");

	pm_block_a: assert property (
		rd_pmcap_s |=> cfg_rdata[7:0] == 8'h01)
		else $error("pm capability id missing at a0");

	capptr_func_a: assert property (
		rd_capstat_s and (cfg_func == 1'b1)[*1] |=> cfg_rdata[15:0] == 16'h00a0)
		else $error("socket 1 pointer wrong");

	socket_apart_a: assert property (
		wr_capstat && !cfg_func && addr_perr[1] == 1'b0 && data_perr[1] == 1'b0
		|=> sock_stat[1][15] == $past(sock_stat[1][15]))
		else $error("socket 0 write touched socket 1");

	w1c_clear_a: assert property (
		clr_perr0_s and quiet_perr0_s |=> !sock_stat[0][15])
		else $error("write one did not clear parity flag");

	parity_set_a: assert property (
		addr_perr[0] || data_perr[0] |=> sock_stat[0][15] [*1])
		else $error("parity error not recorded");

	serr_seen_a: assert property (
		serr0_held_s |=> sock_stat[0][14])
		else $error("card system error not recorded");

	mabort_set_a: assert property (
		master_abort[0] |=> sock_stat[0][13])
		else $error("master abort not recorded");

	tabort_rx_a: assert property (
		target_abort_rx[0] |=> sock_stat[0][12])
		else $error("received target abort not recorded");

	tabort_tx_a: assert property (
		target_abort_tx[0] |=> sock_stat[0][11])
		else $error("signaled target abort not recorded");

	sel_timing_a: assert property (
		sock_stat[0][10:9] == 2'h1 && sock_stat[1][10:9] == 2'h1)
		else $error("select timing code not 01b");

	dpar_cause_a: assert property (
		$rose(sock_stat[0][8]) |-> $past(bus_master[0] && parity_resp_en[0]))
		else $error("data parity flag set without cause");

	fixed_zero_a: assert property (
		sock_stat[0][7:0] == 8'h00 && sock_stat[1][7:0] == 8'h00)
		else $error("fixed or reserved status bit set");

	stat_reset_a: assert property (
		$past(reset) |-> sock_stat[0] == 16'h0200 && sock_stat[1] == 16'h0200)
		else $error("status reset value wrong");

	zero_keeps_a: assert property (
		wr_capstat && !cfg_func && cfg_wdata[31:16] == 16'h0000
		|=> (sock_stat[0] & $past(sock_stat[0])) == $past(sock_stat[0]))
		else $error("writing zero cleared a flag");

	set_wins_a: assert property (
		clr_perr0_s and addr_perr[0] |=> sock_stat[0][15])
		else $error("clear beat a coinciding parity event");

	flags_hold_a: assert property (
		!cfg_req && sock_stat[0][13] |=> sock_stat[0][13])
		else $error("master abort flag lost without write");

	socket1_apart_a: assert property (
		wr_capstat && cfg_func && addr_perr[0] == 1'b0 && data_perr[0] == 1'b0
		|=> sock_stat[0][15] == $past(sock_stat[0][15]))
		else $error("socket 1 write touched socket 0");

	w1c_clear1_a: assert property (
		clr_perr1_s and quiet_perr1_s |=> !sock_stat[1][15])
		else $error("write one did not clear socket 1 parity flag");

	parity_set1_a: assert property (
		addr_perr[1] || data_perr[1] |=> sock_stat[1][15])
		else $error("socket 1 parity error not recorded");

	serr_seen1_a: assert property (
		serr1_held_s |=> sock_stat[1][14])
		else $error("socket 1 card system error not recorded");

	mabort_set1_a: assert property (
		master_abort[1] |=> sock_stat[1][13])
		else $error("socket 1 master abort not recorded");

	tabort_rx1_a: assert property (
		target_abort_rx[1] |=> sock_stat[1][12])
		else $error("socket 1 received target abort not recorded");

	tabort_tx1_a: assert property (
		target_abort_tx[1] |=> sock_stat[1][11])
		else $error("socket 1 signaled target abort not recorded");

	dpar_cause1_a: assert property (
		$rose(sock_stat[1][8]) |-> $past(bus_master[1] && parity_resp_en[1]))
		else $error("socket 1 data parity flag set without cause");

	zero_keeps1_a: assert property (
		wr_capstat && cfg_func && cfg_wdata[31:16] == 16'h0000
		|=> (sock_stat[1] & $past(sock_stat[1])) == $past(sock_stat[1]))
		else $error("writing zero cleared a socket 1 flag");

	set_wins1_a: assert property (
		clr_perr1_s and addr_perr[1] |=> sock_stat[1][15])
		else $error("clear beat a coinciding socket 1 parity event");

	flags_hold1_a: assert property (
		!cfg_req && sock_stat[1][13] |=> sock_stat[1][13])
		else $error("socket 1 master abort flag lost without write");

	perr_cause_a: assert property (
		$rose(sock_stat[0][15]) |-> $past(addr_perr[0] || data_perr[0]))
		else $error("parity flag set without cause");

	perr_cause1_a: assert property (
		$rose(sock_stat[1][15]) |-> $past(addr_perr[1] || data_perr[1]))
		else $error("socket 1 parity flag set without cause");

	mabort_cause_a: assert property (
		$rose(sock_stat[0][13]) |-> $past(master_abort[0]))
		else $error("master abort flag set without cause");

	mabort_cause1_a: assert property (
		$rose(sock_stat[1][13]) |-> $past(master_abort[1]))
		else $error("socket 1 master abort flag set without cause");

	tarx_cause_a: assert property (
		$rose(sock_stat[0][12]) |-> $past(target_abort_rx[0]))
		else $error("received target abort flag set without cause");

	tatx_cause_a: assert property (
		$rose(sock_stat[0][11]) |-> $past(target_abort_tx[0]))
		else $error("signaled target abort flag set without cause");

	stat_read0_a: assert property (
		cfg_req && !cfg_write && hit_capstat && !cfg_func
		|=> cfg_rdata[31:16] == $past(sock_stat[0]))
		else $error("socket 0 status read wrong");

	stat_read1_a: assert property (
		cfg_req && !cfg_write && hit_capstat && cfg_func
		|=> cfg_rdata[31:16] == $past(sock_stat[1]))
		else $error("socket 1 status read wrong");

	cap_byte_zero_a: assert property (
		cfg_req && !cfg_write && hit_capstat |=> cfg_rdata[15:8] == 8'h00)
		else $error("byte between pointer and status not zero");

	pm_block_full_a: assert property (
		rd_pmcap_s |=> cfg_rdata == 32'h00020001)
		else $error("pm capability dword wrong");

	pm_csr_read_a: assert property (
		cfg_req && !cfg_write && hit_pmcsr |=> cfg_rdata[31:2] == 30'h0)
		else $error("pm control upper bits not zero");

	pm_state_wr_a: assert property (
		wr_pmcsr && !cfg_func |=> pstate[0] == $past(cfg_wdata[1:0]))
		else $error("power state write lost");

	pm_state_hold_a: assert property (
		!wr_pmcsr |=> pstate[0] == $past(pstate[0]) && pstate[1] == $past(pstate[1]))
		else $error("power state changed without write");

	unmapped_zero_a: assert property (
		cfg_req && !cfg_write && !hit_capstat && !hit_pmcap && !hit_pmcsr
		|=> cfg_rdata == 32'h00000000)
		else $error("unmapped dword did not read zero");

	rdata_hold_a: assert property (
		!cfg_req || cfg_write |=> $stable(cfg_rdata))
		else $error("read data changed without a read");

	ack_idle_a: assert property (
		!cfg_req |=> !cfg_ack)
		else $error("ack without request");
endmodule // cbss_cfg_regs

//--- test/cbss_host_model.sv
module cbss_host_model
	import cbss_pkg::*;
(
	input  wire logic       clk,       // Host bus clock
	output logic            cfg_req,   // Access strobe
	output logic            cfg_write, // Write select
	output logic            cfg_func,  // Socket function
	output logic [7:0]      cfg_addr,  // Byte address
	output logic [3:0]      cfg_be,    // Byte enables
	output cbss_word_t      cfg_wdata, // Write data
	input  wire logic       cfg_ack,   // Access done
	input  wire cbss_word_t cfg_rdata  // Read data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		cfg_req = 1'b0;
		cfg_write = 1'b0;
		cfg_func = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end

	// One-cycle strobe; qualifiers held until the answer is seen
	task automatic access(input logic wr, input logic fn, input logic [7:0] ad,
		input logic [3:0] be, input cbss_word_t wd, output cbss_word_t rd,
		output logic ok);
		int n;
		@(posedge clk);
		cfg_req <= 1'b1;
		cfg_write <= wr;
		cfg_func <= fn;
		cfg_addr <= ad;
		cfg_be <= be;
		cfg_wdata <= wd;
		@(posedge clk);
		// Strobe taken here; answer sampled on a later edge, qualifiers kept
		cfg_req <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (cfg_ack !== 1'b1 && n < 4);
		ok = (cfg_ack === 1'b1);
		rd = cfg_rdata;
		// Stale data must not look valid
		cfg_wdata <= ~wd;
	endtask
endmodule // cbss_host_model

//--- test/cardbus_secondary_status_capptr_tb.sv
module cardbus_secondary_status_capptr_tb
	import cbss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic [1:0] serr_n = 2'h3;
	logic [1:0] perr_n = 2'h3;
	logic [1:0] mst = 2'h0;
	logic [1:0] resp = 2'h0;
	logic [1:0] ev [5];
	logic       cfg_req, cfg_write, cfg_func, cfg_ack, ok;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be;
	cbss_word_t cfg_wdata, cfg_rdata, rd;
	cbss_status_t ebit [5] = '{16'h8000, 16'h8000, 16'h2000, 16'h1000, 16'h0800};
	cbss_status_t pexp [4] = '{16'h4000, 16'h0100, 16'h0000, 16'h0000};
	int mismatches = 0;
	int compares = 0;
	int seed = 80017;
	int s;

	always #4 clk = ~clk;

	cbss_host_model u_host (.clk(clk), .cfg_req(cfg_req), .cfg_write(cfg_write),
		.cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

	cbss_cfg_regs u_dut (.clk(clk), .reset(reset), .cfg_req(cfg_req),
		.cfg_write(cfg_write), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata), .card_serr_n(serr_n), .card_perr_n(perr_n),
		.bus_master(mst), .parity_resp_en(resp), .addr_perr(ev[0]),
		.data_perr(ev[1]), .master_abort(ev[2]), .target_abort_rx(ev[3]),
		.target_abort_tx(ev[4]));

	function automatic cbss_word_t exp_dw(input cbss_status_t st);
		return {st, 8'h00, 8'ha0};
	endfunction

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input cbss_word_t got, input cbss_word_t exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic wr, input logic fn, input logic [7:0] ad,
		input logic [3:0] be, input cbss_word_t wd);
		u_host.access(wr, fn, ad, be, wd, rd, ok);
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("unexpected at %0t: ack %h expected %h", $time, ok, 1'b1);
			report_and_stop();
		end
	endtask

	task automatic rd_chk(input logic fn, input logic [7:0] ad, input cbss_word_t exp);
		acc(1'b0, fn, ad, 4'hf, 32'h0);
		chk(rd, exp);
	endtask

	task automatic pulse(input int i, input logic sk);
		@(posedge clk);
		ev[i][sk] <= 1'b1;
		@(posedge clk);
		ev[i][sk] <= 1'b0;
	endtask

	initial
	begin
		foreach (ev[i])
			ev[i] = 2'h0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		for (int f = 0; f < 2; f++)
			rd_chk(f[0], 8'h14, exp_dw(16'h0200));
		$display("test reset done");
		s = $random(seed);
		// Random data with ones forced into the pointer, hardwired and reserved bits
		acc(1'b1, s[0], 8'h14, 4'hf, $random(seed) | 32'h06ff00ff);
		rd_chk(s[0], 8'h14, exp_dw(16'h0200));
		rd_chk(!s[0], 8'h14, exp_dw(16'h0200));
		rd_chk(s[0], 8'ha0, 32'h00020001);
		acc(1'b1, s[0], 8'ha4, 4'h1, 32'h00000003);
		rd_chk(s[0], 8'ha4, 32'h00000003);
		rd_chk(!s[0], 8'ha4, 32'h00000000);
		$display("test read-only done");
		for (int i = 0; i < 5; i++)
		begin
			s = $random(seed);
			pulse(i, s[0]);
			rd_chk(s[0], 8'h14, exp_dw(16'h0200 | ebit[i]));
			rd_chk(!s[0], 8'h14, exp_dw(16'h0200));
			acc(1'b1, s[0], 8'h14, 4'hc, 32'h0);
			rd_chk(s[0], 8'h14, exp_dw(16'h0200 | ebit[i]));
			fork
				acc(1'b1, s[0], 8'h14, 4'hc, {ebit[i], 16'h0});
				pulse(i, s[0]);
			join
			rd_chk(s[0], 8'h14, exp_dw(16'h0200 | ebit[i]));
			acc(1'b1, s[0], 8'h14, 4'hc, {ebit[i], 16'h0});
			rd_chk(s[0], 8'h14, exp_dw(16'h0200));
		end
		$display("test events done");
		// Pins pass a synchroniser, so hold them well past its depth
		for (int p = 0; p < 4; p++)
		begin
			s = $random(seed);
			mst <= {2{p != 3}};
			resp <= {2{p != 2}};
			if (p == 0)
				serr_n[s[0]] <= 1'b0;
			else
				perr_n[s[0]] <= 1'b0;
			repeat (8) @(posedge clk);
			serr_n <= 2'h3;
			perr_n <= 2'h3;
			repeat (8) @(posedge clk);
			rd_chk(s[0], 8'h14, exp_dw(16'h0200 | pexp[p]));
			acc(1'b1, s[0], 8'h14, 4'hc, 32'hffff0000);
			rd_chk(s[0], 8'h14, exp_dw(16'h0200));
		end
		$display("test pins done");
		report_and_stop();
	end
endmodule // cardbus_secondary_status_capptr_tb
